/* File: src/awrc_map.svh */
// Register offsets, field positions, reset values and timing counts of the wake/reset block
`ifndef AWRC_MAP_SVH
`define AWRC_MAP_SVH
// Register indices (byte address = 4 * index)
`define AWRC_IDX_GPIO_RST      8'hE5
`define AWRC_IDX_PGOOD_MISC    8'hE6
`define AWRC_IDX_KEYSET_RST    8'hE7
`define AWRC_IDX_GLOBAL_WAKE   8'hF2
`define AWRC_IDX_STATUS_LO     8'hF3
`define AWRC_IDX_STATUS_HI     8'hF4
`define AWRC_IDX_ENABLE_LO     8'hF6
`define AWRC_IDX_ENABLE_HI     8'hF7
`define AWRC_IDX_IRQ_STATUS    8'hF8
`define AWRC_IDX_IRQ_ENABLE    8'hF9
`define AWRC_IDX_IRQ_CLEAR     8'hFA
`define AWRC_IDX_POWER_LOSS    8'hFB
// Reset values
`define AWRC_RST_GPIO_RST      8'h00
`define AWRC_RST_PGOOD_MISC    8'h1C
`define AWRC_RST_KEYSET_RST    8'h00
`define AWRC_RST_GLOBAL_WAKE   8'h3E
`define AWRC_RST_ZERO          8'h00
// Field positions
`define AWRC_E5_GRP_LSB        3
`define AWRC_E5_GRP_MSB        7
`define AWRC_E5_UPPER2         2
`define AWRC_E6_MOUSE_COMBO    7
`define AWRC_E6_CASE_CLR       5
`define AWRC_E6_LAST_STATE     4
`define AWRC_E6_DEL_MSB        3
`define AWRC_E6_DEL_LSB        1
`define AWRC_E6_RETRIG         0
`define AWRC_E7_KEYSET3        7
`define AWRC_E7_KEYSET2        6
`define AWRC_E7_OSKEY          5
`define AWRC_E7_LOSS_PULSE     4
`define AWRC_E7_WDT_SRC        3
`define AWRC_E7_HM_SRC         0
`define AWRC_F2_GLOBAL_EN      0
`define AWRC_F2_MOUSE_R        1
`define AWRC_F2_MOUSE_X        2
`define AWRC_LO_BITS           7
`define AWRC_HI_BITS           6
// Interrupt bits of the block's own events
`define AWRC_IRQ_PGOOD_RISE    0
`define AWRC_IRQ_PSW_PULSE     1
`define AWRC_IRQ_WAKE          2
// Timing
`define AWRC_CLK_HZ            40000000
`define AWRC_PGOOD_LOW_MS      10
`define AWRC_PSW_PULSE_MS      500
// Lower bound of the power-good delay window for each delay code
`define AWRC_DLY0_MS           300
`define AWRC_DLY1_MS           330
`define AWRC_DLY2_MS           390
`define AWRC_DLY3_MS           520
`define AWRC_DLY4_MS           200
`define AWRC_DLY5_MS           230
`define AWRC_DLY6_MS           290
`define AWRC_DLY7_MS           420
`define AWRC_MS_CYCLES         (`AWRC_CLK_HZ / 1000)
`define AWRC_CNT_W             26
`endif

/* File: src/awrc_pkg.sv */
// Types shared by the wake/reset control block
package awrc_pkg;
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } awrc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } awrc_apb_rsp_t;

  // Interrupt events feeding the wake status bits
  typedef struct packed {
    logic serial_port_c;
    logic mouse;
    logic keyboard_controller;
    logic printer_port;
    logic floppy_controller;
    logic serial_port_a;
    logic serial_port_b;
  } awrc_ev_lo_t;

  typedef struct packed {
    logic serial_port_f;
    logic serial_port_e;
    logic hardware_monitor;
    logic watchdog_timeout;
    logic serial_port_d;
    logic ring_indicator_b;
  } awrc_ev_hi_t;

  // Reset steering towards the rest of the chip
  typedef struct packed {
    logic [4:0] gpio_group_reset;
    logic       gpio_group2_upper_pins_reset;
    logic       watchdog_reset;
    logic       hardware_monitor_reset;
  } awrc_rst_out_t;

  typedef enum logic [1:0] {
    AWRC_LOSS_OFF,
    AWRC_LOSS_ON,
    AWRC_LOSS_RESTORE,
    AWRC_LOSS_USER
  } awrc_loss_t;
endpackage : awrc_pkg

/* File: src/awrc_top.sv */
// Wake-event, power-good and reset-source control with an APB register port
`timescale 1ns/100ps
`include "awrc_map.svh"

// Functional notes
// - Group bits 7..3 choose bus reset masking
// - Bit 2: upper group-2 pins use resume reset
// - Case-clear bit pulses clear, self-clears
// - Battery-held last power state flag
// - Delay code selects power-good rise delay
// - Retrigger bit pulses power-good low, self-clears
// - Third key set enables matching
// - Second key set enables matching
// - OS key wakes via power switch
// - Power-loss return gives 0.5 s pulse
// - Watchdog reset: bus reset or power-good
// - Monitor reset: power-good or bus reset
// - Global wake register resets to 3Eh
// - Low status bits latch, write-one clears
// - High status bits latch, write-one clears
// - Mouse combo keys select mouse wake
// - Per-event enables gate wake output
// - Power-loss policy picks restored state
module awrc_top (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // APB
  input  wire awrc_pkg::awrc_apb_req_t apb_req,
  output      awrc_pkg::awrc_apb_rsp_t apb_rsp,
  // Reset sources
  input  wire logic                    bus_reset_n,
  input  wire logic                    resume_well_reset_n,
  input  wire logic                    main_supply_good,
  input  wire logic                    power_loss_return,
  input  wire logic                    power_state_before_loss,
  // Events (pins; ev_lo, ev_hi and os_key_pressed synchronised here, the rest used directly)
  input  wire awrc_pkg::awrc_ev_lo_t   ev_lo,
  input  wire awrc_pkg::awrc_ev_hi_t   ev_hi,
  input  wire logic                    key_set1_match,
  input  wire logic                    key_set2_match,
  input  wire logic                    key_set3_match,
  input  wire logic                    os_key_pressed,
  input  wire logic                    keyboard_wake_enable,
  input  wire logic                    mouse_left_click,
  input  wire logic                    mouse_right_click,
  input  wire logic                    mouse_extra_click,
  // Outputs
  output      logic                    power_good_output,
  output      logic                    power_switch_out_n,
  output      logic                    wake_event_n,
  output      logic                    case_open_clear,
  output      awrc_pkg::awrc_rst_out_t rst_out,
  output      logic                    irq
);
  import awrc_pkg::*;

  localparam int NSYNC = 16;
  localparam logic [`AWRC_CNT_W-1:0] LOW_CYC =
    `AWRC_CNT_W'(`AWRC_PGOOD_LOW_MS * `AWRC_MS_CYCLES);
  localparam logic [`AWRC_CNT_W-1:0] PSW_CYC =
    `AWRC_CNT_W'(`AWRC_PSW_PULSE_MS * `AWRC_MS_CYCLES);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] in_q;
  logic [NSYNC-1:0] in_prev;

  assign async_in = {main_supply_good, power_loss_return, os_key_pressed,
                     ev_lo, ev_hi[5:1], ev_hi[0]};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // A change counts once the second and third stages agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[gi]      <= 1'b0;
          s2[gi]      <= 1'b0;
          s3[gi]      <= 1'b0;
          in_q[gi]    <= 1'b0;
          in_prev[gi] <= 1'b0;
        end else if (clk_en) begin
          s1[gi]      <= async_in[gi];
          s2[gi]      <= s1[gi];
          s3[gi]      <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            in_q[gi] <= s3[gi];
          end
          in_prev[gi] <= in_q[gi];
        end
      end
    end
  endgenerate

  wire       supply_q   = in_q[15];
  wire       loss_rise  = in_q[14] & ~in_prev[14];
  wire       oskey_rise = in_q[13] & ~in_prev[13];
  wire [6:0] lo_rise    = in_q[12:6] & ~in_prev[12:6];
  wire [5:0] hi_rise    = in_q[5:0] & ~in_prev[5:0];

  // ************************************************************
  // APB decode
  // ************************************************************
  logic [7:0] gpio_rst;
  logic [7:0] pg_misc;
  logic [7:0] keyset;
  logic [7:0] gwake;
  logic [6:0] st_lo;
  logic [5:0] st_hi;
  logic [6:0] en_lo;
  logic [5:0] en_hi;
  logic [2:0] irq_st;
  logic [2:0] irq_en;
  logic [1:0] loss_pol;

  wire        acc   = apb_req.psel & apb_req.penable;
  wire        wr    = acc & apb_req.pwrite & clk_en;
  wire [9:0]  idx   = apb_req.paddr[11:2];
  wire [7:0]  wd    = apb_req.pwdata[7:0];
  wire        hit_e5 = idx == {2'b00, `AWRC_IDX_GPIO_RST};
  wire        hit_e6 = idx == {2'b00, `AWRC_IDX_PGOOD_MISC};
  wire        hit_e7 = idx == {2'b00, `AWRC_IDX_KEYSET_RST};
  wire        hit_f2 = idx == {2'b00, `AWRC_IDX_GLOBAL_WAKE};
  wire        hit_f3 = idx == {2'b00, `AWRC_IDX_STATUS_LO};
  wire        hit_f4 = idx == {2'b00, `AWRC_IDX_STATUS_HI};
  wire        hit_f6 = idx == {2'b00, `AWRC_IDX_ENABLE_LO};
  wire        hit_f7 = idx == {2'b00, `AWRC_IDX_ENABLE_HI};
  wire        hit_f8 = idx == {2'b00, `AWRC_IDX_IRQ_STATUS};
  wire        hit_f9 = idx == {2'b00, `AWRC_IDX_IRQ_ENABLE};
  wire        hit_fa = idx == {2'b00, `AWRC_IDX_IRQ_CLEAR};
  wire        hit_fb = idx == {2'b00, `AWRC_IDX_POWER_LOSS};
  wire        mapped = hit_e5 | hit_e6 | hit_e7 | hit_f2 | hit_f3 | hit_f4 | hit_f6
                       | hit_f7 | hit_f8 | hit_f9 | hit_fa | hit_fb;

  wire [7:0] rd_mux =
      hit_e5 ? gpio_rst :
      hit_e6 ? pg_misc :
      hit_e7 ? keyset :
      hit_f2 ? gwake :
      hit_f3 ? {1'b0, st_lo} :
      hit_f4 ? {2'b00, st_hi} :
      hit_f6 ? {1'b0, en_lo} :
      hit_f7 ? {2'b00, en_hi} :
      hit_f8 ? {5'h00, irq_st} :
      hit_f9 ? {5'h00, irq_en} :
      hit_fb ? {6'h00, loss_pol} : 8'h00;

  // Zero wait states; unmapped addresses answer with an error
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~mapped;
  assign apb_rsp.prdata  = {24'h000000, rd_mux};

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic pg_retrig;
  logic case_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_rst <= `AWRC_RST_GPIO_RST;
      keyset   <= `AWRC_RST_KEYSET_RST;
      gwake    <= `AWRC_RST_GLOBAL_WAKE;
      en_lo    <= 7'h00;
      en_hi    <= 6'h00;
      irq_en   <= 3'h0;
      loss_pol <= 2'h0;
    end else if (wr) begin
      if (hit_e5) gpio_rst <= {wd[7:2], 2'b00};
      if (hit_e7) keyset   <= {wd[7:3], 2'b00, wd[0]};
      if (hit_f2) gwake    <= wd;
      if (hit_f6) en_lo    <= wd[6:0];
      if (hit_f7) en_hi    <= wd[5:0];
      if (hit_f9) irq_en   <= wd[2:0];
      if (hit_fb) loss_pol <= wd[1:0];
    end
  end

  // Misc register: the two action bits never hold a 1 beyond one clk_en cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_misc <= `AWRC_RST_PGOOD_MISC;
    end else if (clk_en) begin
      if (wr && hit_e6) begin
        pg_misc <= {wd[7], 1'b0, wd[5:0]};
      end else begin
        pg_misc[`AWRC_E6_CASE_CLR] <= 1'b0;
        pg_misc[`AWRC_E6_RETRIG]   <= 1'b0;
      end
    end
  end

  assign case_clr  = pg_misc[`AWRC_E6_CASE_CLR];
  assign pg_retrig = pg_misc[`AWRC_E6_RETRIG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      case_open_clear <= 1'b0;
    end else if (clk_en) begin
      case_open_clear <= case_clr;
    end
  end

  // ************************************************************
  // Reset source selection
  // ************************************************************
  generate
    for (gi = 0; gi < 5; gi++) begin : g_grp
      // 1 masks the bus reset for that group
      assign rst_out.gpio_group_reset[gi] =
        ~bus_reset_n & ~gpio_rst[`AWRC_E5_GRP_LSB + gi];
    end
  endgenerate

  assign rst_out.gpio_group2_upper_pins_reset = gpio_rst[`AWRC_E5_UPPER2] ?
    ~resume_well_reset_n : ~bus_reset_n;
  assign rst_out.watchdog_reset = keyset[`AWRC_E7_WDT_SRC] ?
    ~power_good_output : ~bus_reset_n;
  assign rst_out.hardware_monitor_reset = keyset[`AWRC_E7_HM_SRC] ?
    ~bus_reset_n : ~power_good_output;

  // ************************************************************
  // Power-good timing
  // ************************************************************
  logic [`AWRC_CNT_W-1:0] pg_cnt;
  logic [`AWRC_CNT_W-1:0] pg_target;
  logic [2:0]             del;
  logic                   pg_rise;

  assign del = pg_misc[`AWRC_E6_DEL_MSB:`AWRC_E6_DEL_LSB];
  // Lower bound of each window is used, so the output never rises early
  always_comb begin
    unique case (del)
      3'h0: pg_target = `AWRC_CNT_W'(`AWRC_DLY0_MS * `AWRC_MS_CYCLES);
      3'h1: pg_target = `AWRC_CNT_W'(`AWRC_DLY1_MS * `AWRC_MS_CYCLES);
      3'h2: pg_target = `AWRC_CNT_W'(`AWRC_DLY2_MS * `AWRC_MS_CYCLES);
      3'h3: pg_target = `AWRC_CNT_W'(`AWRC_DLY3_MS * `AWRC_MS_CYCLES);
      3'h4: pg_target = `AWRC_CNT_W'(`AWRC_DLY4_MS * `AWRC_MS_CYCLES);
      3'h5: pg_target = `AWRC_CNT_W'(`AWRC_DLY5_MS * `AWRC_MS_CYCLES);
      3'h6: pg_target = `AWRC_CNT_W'(`AWRC_DLY6_MS * `AWRC_MS_CYCLES);
      3'h7: pg_target = `AWRC_CNT_W'(`AWRC_DLY7_MS * `AWRC_MS_CYCLES);
    endcase
  end

  logic pg_hold;   // Forced-low phase of a retrigger
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_cnt            <= '0;
      pg_hold           <= 1'b0;
      power_good_output <= 1'b0;
    end else if (clk_en) begin
      if (!supply_q || pg_retrig) begin
        pg_cnt            <= '0;
        pg_hold           <= pg_retrig;
        power_good_output <= 1'b0;
      end else if (pg_hold) begin
        pg_cnt  <= pg_cnt + 1'b1;
        if (pg_cnt >= LOW_CYC) begin
          pg_hold <= 1'b0;
          pg_cnt  <= '0;
        end
      end else if (!power_good_output) begin
        pg_cnt <= pg_cnt + 1'b1;
        if (pg_cnt >= pg_target) begin
          power_good_output <= 1'b1;
        end
      end
    end
  end
  assign pg_rise = supply_q & ~pg_hold & ~power_good_output & (pg_cnt >= pg_target);

  // ************************************************************
  // Power-loss recovery and keyboard/mouse wake
  // ************************************************************
  awrc_loss_t pol;
  logic       want_on;
  assign pol = awrc_loss_t'(loss_pol);
  always_comb begin
    unique case (pol)
      AWRC_LOSS_OFF:     want_on = 1'b0;
      AWRC_LOSS_ON:      want_on = 1'b1;
      AWRC_LOSS_RESTORE: want_on = power_state_before_loss;
      AWRC_LOSS_USER:    want_on = ~pg_misc[`AWRC_E6_LAST_STATE];
    endcase
  end

  wire key_wake = keyboard_wake_enable & (key_set1_match
                  | (keyset[`AWRC_E7_KEYSET2] & key_set2_match)
                  | (keyset[`AWRC_E7_KEYSET3] & key_set3_match)
                  | (keyset[`AWRC_E7_OSKEY] & oskey_rise));

  wire mouse_wake = pg_misc[`AWRC_E6_MOUSE_COMBO] ? mouse_left_click :
                    ((gwake[`AWRC_F2_MOUSE_R] & mouse_right_click)
                     | (gwake[`AWRC_F2_MOUSE_X] & mouse_extra_click));

  logic [`AWRC_CNT_W-1:0] psw_cnt;
  logic                   psw_fire;
  wire                    loss_start = loss_rise & want_on & keyset[`AWRC_E7_LOSS_PULSE];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psw_cnt            <= '0;
      power_switch_out_n <= 1'b1;
    end else if (clk_en) begin
      if (loss_start) begin
        psw_cnt            <= PSW_CYC;
        power_switch_out_n <= 1'b0;
      end else if (psw_cnt != '0) begin
        psw_cnt <= psw_cnt - 1'b1;
        if (psw_cnt == `AWRC_CNT_W'(1)) power_switch_out_n <= 1'b1;
      end else begin
        power_switch_out_n <= ~(key_wake | mouse_wake);
      end
    end
  end
  assign psw_fire = loss_start;

  // ************************************************************
  // Wake event status and interrupt
  // ************************************************************
  wire       clr_lo = wr & hit_f3;
  wire       clr_hi = wr & hit_f4;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_lo <= 7'h00;
      st_hi <= 6'h00;
    end else if (clk_en) begin
      // A new event wins over a same-cycle clear
      st_lo <= (st_lo & ~({7{clr_lo}} & wd[6:0])) | lo_rise;
      st_hi <= (st_hi & ~({6{clr_hi}} & wd[5:0])) | hi_rise;
    end
  end

  wire pend = |(st_lo & en_lo) | |(st_hi & en_hi);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_event_n <= 1'b1;
    end else if (clk_en) begin
      wake_event_n <= ~(gwake[`AWRC_F2_GLOBAL_EN] & pend);
    end
  end

  wire [2:0] irq_set;
  assign irq_set[`AWRC_IRQ_PGOOD_RISE] = pg_rise;
  assign irq_set[`AWRC_IRQ_PSW_PULSE]  = psw_fire;
  assign irq_set[`AWRC_IRQ_WAKE]       = |lo_rise | |hi_rise;
  wire [2:0] irq_clr = (wr & hit_fa) ? wd[2:0] : 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st <= 3'h0;
    end else if (clk_en) begin
      irq_st <= (irq_st & ~irq_clr) | irq_set;
    end
  end
  assign irq = |(irq_st & irq_en);

endmodule : awrc_top

/* File: sim/awrc_checker_asserts.sv */
// Concurrent checks on the ports of the wake/reset control block
`timescale 1ns/100ps
module awrc_checker (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    clk_en,
  // Register bus
  input wire awrc_pkg::awrc_apb_req_t apb_req,
  input wire awrc_pkg::awrc_apb_rsp_t apb_rsp,
  // Reset sources and outputs
  input wire logic                    bus_reset_n,
  input wire logic                    resume_well_reset_n,
  input wire logic                    power_good_output,
  input wire logic                    case_open_clear,
  input wire logic                    wake_event_n,
  input wire awrc_pkg::awrc_rst_out_t rst_out,
  input wire logic                    irq
);
  import awrc_pkg::*;
  logic [7:0] idx;
  logic [7:0] d;
  logic       acc;
  logic       wr;
  logic       mapped;
  assign idx = apb_req.paddr[9:2];
  assign d   = apb_req.pwdata[7:0];
  assign acc = apb_req.psel & apb_req.penable;
  assign wr  = acc & apb_req.pwrite & clk_en & mapped;
  assign mapped = (apb_req.paddr[11:10] == 2'h0) &&
                  (idx inside {8'hE5, 8'hE6, 8'hE7, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'hF7,
                               8'hF8, 8'hF9, 8'hFA, 8'hFB});
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_a: assert property (acc |-> apb_rsp.pready) else $error("no ready in access phase");
  unmapped_err_a: assert property (acc |-> apb_rsp.pslverr == !mapped)
    else $error("slave error does not match address map");
  unmapped_zero_a: assert property (acc && !mapped && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
    else $error("unmapped read not zero");
  gpio_mask_a: assert property (wr && idx == 8'hE5 |=>
    rst_out.gpio_group_reset == ({5{!bus_reset_n}} & ~$past(d[7:3])))
    else $error("group reset steering wrong");
  upper_src_a: assert property (wr && idx == 8'hE5 |=>
    rst_out.gpio_group2_upper_pins_reset == ($past(d[2]) ? !resume_well_reset_n : !bus_reset_n))
    else $error("upper pin reset source wrong");
  wdt_src_a: assert property (wr && idx == 8'hE7 |=>
    rst_out.watchdog_reset == ($past(d[3]) ? !power_good_output : !bus_reset_n))
    else $error("watchdog reset source wrong");
  hm_src_a: assert property (wr && idx == 8'hE7 |=>
    rst_out.hardware_monitor_reset == ($past(d[0]) ? !bus_reset_n : !power_good_output))
    else $error("monitor reset source wrong");
  case_clear_a: assert property (wr && idx == 8'hE6 && d[5] |-> ##[1:2] case_open_clear)
    else $error("case clear not pulsed");
  case_pulse_a: assert property ($rose(case_open_clear) |=> !case_open_clear)
    else $error("case clear longer than one cycle");
  retrig_low_a: assert property (wr && idx == 8'hE6 && d[0] |-> ##[1:2] !power_good_output)
    else $error("power good not dropped on retrigger");
  wake_off_a: assert property (wr && idx == 8'hF2 && !d[0] |-> ##[1:2] wake_event_n)
    else $error("wake output active with global enable off");
  irq_mask_a: assert property (wr && idx == 8'hF9 && d == 8'h00 |=> !irq)
    else $error("interrupt high while all masked");
endmodule : awrc_checker

bind awrc_top awrc_checker i_awrc_checker (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .bus_reset_n(bus_reset_n), .resume_well_reset_n(resume_well_reset_n),
  .power_good_output(power_good_output), .case_open_clear(case_open_clear),
  .wake_event_n(wake_event_n), .rst_out(rst_out), .irq(irq)
);

/* File: sim/awrc_host_model.sv */
// Host chipset model: bus reset, resume reset and supply levels
`timescale 1ns/100ps
module awrc_host_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench control
  input  wire logic bus_reset_req,
  input  wire logic loss_req,
  // Levels towards the block
  output      logic bus_reset_n,
  output      logic resume_well_reset_n,
  output      logic main_supply_good,
  output      logic power_loss_return,
  output      logic power_state_before_loss
);
  logic [1:0] up_cnt;
  // Main rail held off: the power-good rise delay of 200 ms and more would outlast the run
  assign main_supply_good        = 1'b0;
  assign power_loss_return       = loss_req;
  assign power_state_before_loss = 1'b1;
  // Resume reset leaves a few cycles after the standby well is up, bus reset after that
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt              <= 2'h0;
      resume_well_reset_n <= 1'b0;
      bus_reset_n         <= 1'b0;
    end else begin
      if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
      resume_well_reset_n <= (up_cnt >= 2'h2);
      bus_reset_n         <= (up_cnt == 2'h3) && !bus_reset_req;
    end
  end
endmodule : awrc_host_model

/* File: sim/acpi_wake_reset_control_tb.sv */
// Self-checking bench of the wake/reset control block
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module acpi_wake_reset_control_tb;
  import awrc_pkg::*;
  logic pclk, presetn, clk_en, bus_reset_req, loss_req;
  logic bus_reset_n, resume_well_reset_n, main_supply_good, power_loss_return, pstate;
  logic ks1, ks2, ks3, os_key, kbd_en, ms_l, ms_r, ms_x, last_err;
  logic power_good_output, power_switch_out_n, wake_event_n, case_open_clear, irq;
  awrc_apb_req_t apb_req;
  awrc_apb_rsp_t apb_rsp;
  awrc_ev_lo_t   ev_lo;
  awrc_ev_hi_t   ev_hi;
  awrc_rst_out_t rst_out;
  int bad_count = 0;
  int tests_run = 0;

  awrc_top i_awrc_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .bus_reset_n(bus_reset_n), .resume_well_reset_n(resume_well_reset_n),
    .main_supply_good(main_supply_good), .power_loss_return(power_loss_return),
    .power_state_before_loss(pstate), .ev_lo(ev_lo), .ev_hi(ev_hi), .key_set1_match(ks1),
    .key_set2_match(ks2), .key_set3_match(ks3), .os_key_pressed(os_key),
    .keyboard_wake_enable(kbd_en), .mouse_left_click(ms_l), .mouse_right_click(ms_r),
    .mouse_extra_click(ms_x), .power_good_output(power_good_output),
    .power_switch_out_n(power_switch_out_n), .wake_event_n(wake_event_n),
    .case_open_clear(case_open_clear), .rst_out(rst_out), .irq(irq));
  awrc_host_model i_awrc_host_model (.pclk(pclk), .presetn(presetn),
    .bus_reset_req(bus_reset_req), .loss_req(loss_req), .bus_reset_n(bus_reset_n),
    .resume_well_reset_n(resume_well_reset_n), .main_supply_good(main_supply_good),
    .power_loss_return(power_loss_return), .power_state_before_loss(pstate));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'h0, idx, 2'h0},
                 pwdata: {24'h0, wd}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata[7:0];
    last_err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  // Two falling edges let a write and the registered outputs behind it settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    apb(1'b1, idx, wd, r);
    repeat (2) @(negedge pclk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    apb(1'b0, idx, 8'h00, r);
    `CHK(r, exp)
  endtask : rd_chk

  task automatic t_defaults;
    rd_chk(8'hE5, 8'h00);
    rd_chk(8'hE6, 8'h1C);
    rd_chk(8'hE7, 8'h00);
    rd_chk(8'hF2, 8'h3E);
    rd_chk(8'hF3, 8'h00);
    rd_chk(8'hF4, 8'h00);
    rd_chk(8'hE8, 8'h00);
    `CHK(last_err, 1'b1)
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_steer;
    bus_reset_req <= 1'b1;
    wr(8'hE5, 8'hF8);
    `CHK(rst_out.gpio_group_reset, 5'h00)
    `CHK(rst_out.gpio_group2_upper_pins_reset, 1'b1)
    wr(8'hE5, 8'h04);
    `CHK(rst_out.gpio_group_reset, 5'h1F)
    `CHK(rst_out.gpio_group2_upper_pins_reset, 1'b0)
    rd_chk(8'hE5, 8'h04);
    // Clock enable low: the write must not land
    clk_en <= 1'b0;
    wr(8'hE5, 8'hFF);
    @(posedge pclk);
    clk_en <= 1'b1;
    rd_chk(8'hE5, 8'h04);
    bus_reset_req <= 1'b0;
    wr(8'hE7, 8'h09);
    `CHK(rst_out.watchdog_reset, 1'b1)
    `CHK(rst_out.hardware_monitor_reset, 1'b0)
    wr(8'hE7, 8'h00);
    `CHK(rst_out.watchdog_reset, 1'b0)
    `CHK(rst_out.hardware_monitor_reset, 1'b1)
    $display("test steer done");
  endtask : t_steer

  task automatic t_misc;
    for (int c = 0; c < 8; c++) begin
      wr(8'hE6, {4'h1, c[2:0], 1'b0});
      rd_chk(8'hE6, {4'h1, c[2:0], 1'b0});
    end
    wr(8'hE6, 8'h3C);
    `CHK(case_open_clear, 1'b1)
    rd_chk(8'hE6, 8'h1C);
    wr(8'hE6, 8'h8F);
    rd_chk(8'hE6, 8'h8E);
    `CHK(power_good_output, 1'b0)
    wr(8'hE6, 8'h1C);
    $display("test misc done");
  endtask : t_misc

  task automatic t_status;
    wr(8'hF6, 8'h7E);
    wr(8'hF7, 8'h3F);
    wr(8'hF9, 8'h04);
    @(posedge pclk);
    ev_lo <= 7'h7F;
    ev_hi <= 6'h3F;
    repeat (2) @(posedge pclk);
    ev_lo <= 7'h00;
    ev_hi <= 6'h00;
    repeat (10) @(posedge pclk);
    rd_chk(8'hF3, 8'h7F);
    rd_chk(8'hF4, 8'h3F);
    `CHK(wake_event_n, 1'b1)
    `CHK(irq, 1'b1)
    wr(8'hF2, 8'h3F);
    `CHK(wake_event_n, 1'b0)
    wr(8'hF3, 8'h7E);
    wr(8'hF4, 8'h3F);
    `CHK(wake_event_n, 1'b1)
    rd_chk(8'hF3, 8'h01);
    rd_chk(8'hF4, 8'h00);
    wr(8'hF3, 8'h01);
    rd_chk(8'hF3, 8'h00);
    wr(8'hF9, 8'h00);
    `CHK(irq, 1'b0)
    wr(8'hF9, 8'h04);
    `CHK(irq, 1'b1)
    wr(8'hFA, 8'h04);
    `CHK(irq, 1'b0)
    wr(8'hF2, 8'h3E);
    $display("test status done");
  endtask : t_status

  task automatic t_keys;
    int n;
    n = 0;
    @(posedge pclk);
    kbd_en <= 1'b1;
    {ks2, ks3, os_key} <= 3'h7;
    repeat (3) @(posedge pclk);
    {ks2, ks3, os_key} <= 3'h0;
    repeat (20) @(posedge pclk);
    `CHK(power_switch_out_n, 1'b1)
    wr(8'hE7, 8'h40);
    @(posedge pclk);
    ks2 <= 1'b1;
    repeat (3) @(posedge pclk);
    ks2 <= 1'b0;
    while (power_switch_out_n !== 1'b0 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    `CHK(power_switch_out_n, 1'b0)
    $display("test keys done");
  endtask : t_keys

  // Policy off gives no power-switch pulse, policy on gives one; kept last,
  // as the pulse outlasts the run
  task automatic t_loss;
    wr(8'hE7, 8'h10);
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      loss_req <= 1'b1;
      repeat (8) @(posedge pclk);
      loss_req <= 1'b0;
      @(negedge pclk);
      `CHK(power_switch_out_n, p == 0)
      wr(8'hFB, 8'h01);
    end
    rd_chk(8'hF8, 8'h02);
    $display("test loss done");
  endtask : t_loss

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  initial begin
    #1ms;
    bad_count++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    bus_reset_req = 1'b0;
    apb_req = '0;
    ev_lo = '0;
    ev_hi = '0;
    {ks1, ks2, ks3, os_key, kbd_en, ms_l, ms_r, ms_x, last_err, loss_req} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_defaults();
    t_steer();
    t_misc();
    t_status();
    t_keys();
    t_loss();
    give_verdict();
  end
endmodule : acpi_wake_reset_control_tb
